// ### design/rtcac_defs.svh
// ==========================================
`ifndef RTCAC_DEFS_SVH
`define RTCAC_DEFS_SVH
// ==========================================
// Register offsets
`define RTCAC_A_SEC   4'h0
`define RTCAC_A_MIN   4'h1
`define RTCAC_A_HOUR  4'h2
`define RTCAC_A_WDAY  4'h3
`define RTCAC_A_DATE  4'h4
`define RTCAC_A_MON   4'h5
`define RTCAC_A_YEAR  4'h6
`define RTCAC_A_TRIM  4'h7
`define RTCAC_A_A1M   4'h8
`define RTCAC_A_A1H   4'h9
`define RTCAC_A_A1W   4'hA
`define RTCAC_A_A2M   4'hB
`define RTCAC_A_A2H   4'hC
`define RTCAC_A_A2W   4'hD
`define RTCAC_A_C1    4'hE
`define RTCAC_A_C2    4'hF
// ==========================================
// Implemented-bit masks, index order F..0
`define RTCAC_MASKS {8'h3F, 8'hFF, 8'h7F, 8'h3F, 8'h7F, 8'h7F, 8'h3F, 8'h7F, \
                     8'hFF, 8'hFF, 8'h1F, 8'h3F, 8'h07, 8'h3F, 8'h7F, 8'h7F}
// ==========================================
// Field positions
`define RTCAC_T_XSL   7
`define RTCAC_C1_A1E  7
`define RTCAC_C1_A2E  6
`define RTCAC_C1_SLH  5
`define RTCAC_C1_SLL  4
`define RTCAC_C2_OSC_HALT_STATUS 4
`define RTCAC_C2_CLOCK_OUT_CONTROL 3
`define RTCAC_C2_PERIODIC_STATE_FLAG 2
`define RTCAC_C2_A1F  1
`define RTCAC_C2_A2F  0
// ==========================================
// Reset values
`define RTCAC_RST_DATE 8'h01
`define RTCAC_RST_MON  8'h01
`define RTCAC_RST_C2   8'h10
// ==========================================
// Timing
`define RTCAC_DIV_FAST  32768
`define RTCAC_DIV_SLOW  32000
`define RTCAC_TRIM_SECS 20
`define RTCAC_HALT_MS   1000
`define RTCAC_SYS_KHZ   25000
// Bus address, arbitrary value
`define RTCAC_DEV_ADDR  7'h51
`endif

// ### design/rtcac_pkg.sv
package rtcac_pkg;
    // ==========================================
    // Serial slave states
    typedef enum logic [2:0] {
        SL_IDLE,
        SL_ADDR,
        SL_ACK,
        SL_WRITE,
        SL_WACK,
        SL_READ,
        SL_RACK
    } rtcac_sl_t;

    // ==========================================
    // Serial slave state
    typedef struct packed {
        rtcac_sl_t  st;
        logic [7:0] sh;
        logic [3:0] cnt;
        logic [3:0] ptr;
        logic       rw;
        logic       first;
        logic       inc;
        logic       nack;
        logic       oe;
        logic       wr;
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
    } rtcac_i2c_t;

    // ==========================================
    // Oscillator-domain state
    typedef struct packed {
        logic [7:0]  t1;
        logic [7:0]  t2;
        logic        e1;
        logic        e2;
        logic [15:0] cnt;
        logic [4:0]  s20;
        logic [1:0]  g;
    } rtcac_osc_t;

    // ==========================================
    // System-domain state
    typedef struct packed {
        logic [15:0][7:0] r;
        logic [1:0]       g1;
        logic [1:0]       g2;
        logic [1:0]       ph;
        logic [31:0]      wd;
        logic             irq1;
        logic             irq2;
    } rtcac_core_t;
endpackage : rtcac_pkg

// ### design/rtcac_i2c_slave.sv
`timescale 1ns/1ns
`default_nettype none
`include "rtcac_defs.svh"

module rtcac_i2c_slave #(
    parameter logic [6:0] DEV_ADDR = `RTCAC_DEV_ADDR
) (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    output logic            wr_pulse,
    output logic [3:0]      reg_addr,
    output logic [7:0]      wr_data,
    input  wire logic [7:0] rd_data
);
    rtcac_pkg::rtcac_i2c_t st_reg;
    rtcac_pkg::rtcac_i2c_t st_next;
    logic                  rise;
    logic                  fall;
    logic                  start;
    logic                  stop;

    // Edges seen on the second sync stage only
    assign rise  = st_reg.s2[1] & ~st_reg.s3[1];
    assign fall  = ~st_reg.s2[1] & st_reg.s3[1];
    assign start = st_reg.s2[1] & st_reg.s3[1] & st_reg.s3[0] & ~st_reg.s2[0];
    assign stop  = st_reg.s2[1] & st_reg.s3[1] & ~st_reg.s3[0] & st_reg.s2[0];

    assign sda_out  = 1'b0;
    assign sda_oe   = st_reg.oe;
    assign wr_pulse = st_reg.wr;
    assign reg_addr = st_reg.ptr;
    assign wr_data  = st_reg.sh;

    // ==========================================
    // Byte framing, ack and auto-increment
    always_comb begin
        st_next    = st_reg;
        st_next.s1 = {scl_in, sda_in};
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        st_next.wr = 1'b0;
        if (start) begin
            st_next.st    = rtcac_pkg::SL_ADDR;
            st_next.cnt   = 4'h0;
            st_next.oe    = 1'b0;
            st_next.first = 1'b1;
        end else if (stop) begin
            st_next.st = rtcac_pkg::SL_IDLE;
            st_next.oe = 1'b0;
        end else begin
            case (st_reg.st)
                rtcac_pkg::SL_ADDR, rtcac_pkg::SL_WRITE: begin
                    if (rise) begin
                        st_next.sh  = {st_reg.sh[6:0], st_reg.s2[0]};
                        st_next.cnt = st_reg.cnt + 4'h1;
                    end else if (fall && st_reg.cnt == 4'h8) begin
                        st_next.cnt = 4'h0;
                        st_next.oe  = 1'b1;
                        if (st_reg.st == rtcac_pkg::SL_ADDR) begin
                            st_next.rw = st_reg.sh[0];
                            st_next.st = rtcac_pkg::SL_ACK;
                            if (st_reg.sh[7:1] != DEV_ADDR) begin
                                st_next.oe = 1'b0;
                                st_next.st = rtcac_pkg::SL_IDLE;
                            end
                        end else begin
                            st_next.st  = rtcac_pkg::SL_WACK;
                            st_next.inc = ~st_reg.first;
                            st_next.wr  = ~st_reg.first;
                            if (st_reg.first) begin
                                st_next.ptr   = st_reg.sh[3:0];
                                st_next.first = 1'b0;
                            end
                        end
                    end
                end
                rtcac_pkg::SL_ACK: begin
                    if (fall) begin
                        st_next.oe = 1'b0;
                        st_next.st = rtcac_pkg::SL_WRITE;
                        if (st_reg.rw) begin
                            st_next.sh = rd_data;
                            st_next.oe = ~rd_data[7];
                            st_next.st = rtcac_pkg::SL_READ;
                        end
                    end
                end
                rtcac_pkg::SL_WACK: begin
                    if (fall) begin
                        st_next.oe  = 1'b0;
                        st_next.st  = rtcac_pkg::SL_WRITE;
                        st_next.ptr = st_reg.ptr + {3'h0, st_reg.inc};
                    end
                end
                rtcac_pkg::SL_READ: begin
                    if (rise) begin
                        st_next.cnt = st_reg.cnt + 4'h1;
                    end else if (fall && st_reg.cnt == 4'h8) begin
                        st_next.oe  = 1'b0;
                        st_next.ptr = st_reg.ptr + 4'h1;
                        st_next.st  = rtcac_pkg::SL_RACK;
                    end else if (fall) begin
                        st_next.sh = {st_reg.sh[6:0], 1'b0};
                        st_next.oe = ~st_reg.sh[6];
                    end
                end
                rtcac_pkg::SL_RACK: begin
                    if (rise) begin
                        st_next.nack = st_reg.s2[0];
                    end else if (fall && st_reg.nack) begin
                        st_next.st = rtcac_pkg::SL_IDLE;
                    end else if (fall) begin
                        st_next.sh  = rd_data;
                        st_next.oe  = ~rd_data[7];
                        st_next.cnt = 4'h0;
                        st_next.st  = rtcac_pkg::SL_READ;
                    end
                end
                default: begin
                    st_next.oe = 1'b0;
                end
            endcase
        end
    end

    // State register, lines idle high at reset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_reg    <= '0;
            st_reg.s1 <= 2'h3;
            st_reg.s2 <= 2'h3;
            st_reg.s3 <= 2'h3;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule : rtcac_i2c_slave
`default_nettype wire

// ### design/rtcac_core.sv
`timescale 1ns/1ns
`default_nettype none
`include "rtcac_defs.svh"

module rtcac_core #(
    parameter int DIV_FAST  = `RTCAC_DIV_FAST,
    parameter int DIV_SLOW  = `RTCAC_DIV_SLOW,
    parameter int TRIM_SECS = `RTCAC_TRIM_SECS,
    parameter int HALT_CYC  = `RTCAC_HALT_MS * `RTCAC_SYS_KHZ
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic osc_clk,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    output logic      irq_pin_one_out,
    output logic      irq_pin_one_oe,
    output logic      irq_pin_two_out,
    output logic      irq_pin_two_oe,
    output logic      crystal_clock_out_pin
);
    localparam logic [15:0][7:0] MASKS = `RTCAC_MASKS;

    rtcac_pkg::rtcac_osc_t  o_reg;
    rtcac_pkg::rtcac_osc_t  o_next;
    rtcac_pkg::rtcac_core_t st_reg;
    rtcac_pkg::rtcac_core_t st_next;

    logic        wr_pulse;
    logic [3:0]  reg_addr;
    logic [7:0]  wr_data;
    logic [7:0]  rd_data;
    logic [15:0] base;
    logic [15:0] len;
    logic [1:0]  phase;
    logic [1:0]  phd;
    logic        tick;
    logic        dead;
    logic        per_act;
    logic        a1_act;
    logic        a2_act;
    logic [8:0]  inc;
    logic        carry;
    logic [7:0]  d;
    logic [7:0]  c2;

    // ==========================================
    // Helpers
    // Register mask lookup
    function automatic logic [7:0] reg_mask(input logic [3:0] a);
        reg_mask = MASKS[a];
    endfunction : reg_mask

    // BCD step with carry out, wraps to low at lim
    function automatic logic [8:0] bcd_inc(input logic [7:0] v,
                                           input logic [7:0] lim,
                                           input logic [7:0] low);
        if (v >= lim) begin
            bcd_inc = {1'b1, low};
        end else if (v[3:0] >= 4'h9) begin
            bcd_inc = {1'b0, v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {1'b0, v + 8'h01};
        end
    endfunction : bcd_inc

    // BCD year multiple of four, century ignored
    function automatic logic leap(input logic [7:0] y);
        if (y[4]) begin
            leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end else begin
            leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
        end
    endfunction : leap

    // Last date of a month, in BCD
    function automatic logic [7:0] mdays(input logic [7:0] m,
                                         input logic [7:0] y);
        case (m)
            8'h02: begin
                mdays = leap(y) ? 8'h29 : 8'h28;
            end
            8'h04, 8'h06, 8'h09, 8'h11: begin
                mdays = 8'h30;
            end
            default: begin
                mdays = 8'h31;
            end
        endcase
    endfunction : mdays

    // ==========================================
    // Serial register port
    rtcac_i2c_slave u_bus (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .sda_out  (sda_out),
        .sda_oe   (sda_oe),
        .wr_pulse (wr_pulse),
        .reg_addr (reg_addr),
        .wr_data  (wr_data),
        .rd_data  (rd_data)
    );

    // ==========================================
    // Oscillator domain: prescaler and trimming
    // Trim is quasi-static, so a per-bit sync is enough
    always_comb begin
        base = o_reg.t2[`RTCAC_T_XSL] ? 16'(DIV_SLOW) : 16'(DIV_FAST);
        len  = base;
        if (o_reg.s20 == 5'(TRIM_SECS - 1)) begin
            len = base - {{8{o_reg.t2[6]}}, o_reg.t2[6:0], 1'b0};
        end
        if (o_reg.cnt >= base - (base >> 2)) begin
            phase = 2'd3;
        end else if (o_reg.cnt >= (base >> 1)) begin
            phase = 2'd2;
        end else if (o_reg.cnt >= (base >> 2)) begin
            phase = 2'd1;
        end else begin
            phase = 2'd0;
        end
        o_next    = o_reg;
        o_next.t1 = st_reg.r[`RTCAC_A_TRIM];
        o_next.t2 = o_reg.t1;
        o_next.e1 = ~st_reg.r[`RTCAC_A_C2][`RTCAC_C2_CLOCK_OUT_CONTROL];
        o_next.e2 = o_reg.e1;
        o_next.g  = {phase[1], phase[1] ^ phase[0]};
        o_next.cnt = o_reg.cnt + 16'h0001;
        if (o_reg.cnt >= len - 16'h0001) begin
            o_next.cnt = 16'h0000;
            o_next.s20 = o_reg.s20 + 5'h01;
            if (o_reg.s20 >= 5'(TRIM_SECS - 1)) begin
                o_next.s20 = 5'h00;
            end
        end
    end

    // Oscillator-domain register
    always_ff @(posedge osc_clk or posedge rst) begin
        if (rst) begin
            o_reg <= '0;
        end else begin
            o_reg <= o_next;
        end
    end

    // Clock may clip its high phase when enable flips
    assign crystal_clock_out_pin = osc_clk & o_reg.e2;
    // ==========================================
    // Pins: active-low open drain, clock shares pin two
    assign irq_pin_one_out = 1'b0;
    assign irq_pin_two_out = 1'b0;
    assign irq_pin_one_oe  = st_reg.irq1;
    assign irq_pin_two_oe  = st_reg.irq2 | (o_reg.e2 & ~osc_clk);

    // ==========================================
    // Status decode from registered state
    always_comb begin
        phd  = {st_reg.g2[1], st_reg.g2[1] ^ st_reg.g2[0]};
        tick = (st_reg.ph == 2'd3) && (phd == 2'd0);
        dead = (st_reg.wd == 32'(HALT_CYC));
        case (st_reg.r[`RTCAC_A_C1][2:0])
            3'h0: begin
                per_act = 1'b0;
            end
            3'h1: begin
                per_act = 1'b1;
            end
            3'h2: begin
                per_act = ~st_reg.ph[0];
            end
            3'h3: begin
                per_act = ~st_reg.ph[1];
            end
            default: begin
                per_act = st_reg.r[`RTCAC_A_C2][`RTCAC_C2_PERIODIC_STATE_FLAG];
            end
        endcase
        a1_act = st_reg.r[`RTCAC_A_C2][`RTCAC_C2_A1F];
        a2_act = st_reg.r[`RTCAC_A_C2][`RTCAC_C2_A2F];
        rd_data = st_reg.r[reg_addr] & reg_mask(reg_addr);
        if (reg_addr == `RTCAC_A_C2) begin
            rd_data[`RTCAC_C2_PERIODIC_STATE_FLAG] = per_act;
        end
    end

    // ==========================================
    // Timekeeping, alarms, register writes
    always_comb begin
        st_next    = st_reg;
        st_next.g1 = o_reg.g;
        st_next.g2 = st_reg.g1;
        st_next.ph = phd;
        carry      = 1'b0;
        inc        = 9'h000;
        d          = wr_data & reg_mask(reg_addr);
        c2         = st_reg.r[`RTCAC_A_C2];
        // Watchdog on phase activity
        if (phd != st_reg.ph) begin
            st_next.wd = 32'h0000_0000;
        end else if (!dead) begin
            st_next.wd = st_reg.wd + 32'h0000_0001;
        end
        // Carry chain, two year digits only
        if (tick) begin
            inc = bcd_inc(st_reg.r[0], 8'h59, 8'h00);
            {carry, st_next.r[0]} = inc;
            if (carry) begin
                inc = bcd_inc(st_reg.r[1], 8'h59, 8'h00);
                {carry, st_next.r[1]} = inc;
            end
            if (carry) begin
                inc = bcd_inc(st_reg.r[2], 8'h23, 8'h00);
                {carry, st_next.r[2]} = inc;
            end
            if (carry) begin
                st_next.r[3] = (st_reg.r[3] >= 8'h06) ? 8'h00 : st_reg.r[3] + 8'h01;
                inc = bcd_inc(st_reg.r[4], mdays(st_reg.r[5], st_reg.r[6]), 8'h01);
                {carry, st_next.r[4]} = inc;
            end
            if (carry) begin
                inc = bcd_inc(st_reg.r[5], 8'h12, 8'h01);
                {carry, st_next.r[5]} = inc;
            end
            if (carry) begin
                inc = bcd_inc(st_reg.r[6], 8'h99, 8'h00);
                {carry, st_next.r[6]} = inc;
            end
        end
        // Host write overrides a same-cycle count
        if (wr_pulse && reg_addr != `RTCAC_A_C2) begin
            st_next.r[reg_addr] = d;
        end else if (wr_pulse) begin
            // Flags 2:0: writing zero clears, one keeps; halt clears on any write while the oscillator runs
            st_next.r[`RTCAC_A_C2] = {2'b00, d[5], c2[4], d[3], c2[2:0] & d[2:0]};
            if (!dead) begin
                st_next.r[`RTCAC_A_C2][`RTCAC_C2_OSC_HALT_STATUS] = 1'b0;
            end
        end
        // Event sets after clears, so sets win
        if (tick && st_next.r[0] == 8'h00) begin
            if (st_next.r[1] == st_reg.r[`RTCAC_A_A1M]
                && st_next.r[2] == st_reg.r[`RTCAC_A_A1H]
                && st_reg.r[`RTCAC_A_A1W][st_next.r[3][2:0]]) begin
                st_next.r[`RTCAC_A_C2][`RTCAC_C2_A1F] = 1'b1;
            end
            if (st_next.r[1] == st_reg.r[`RTCAC_A_A2M]
                && st_next.r[2] == st_reg.r[`RTCAC_A_A2H]
                && st_reg.r[`RTCAC_A_A2W][st_next.r[3][2:0]]) begin
                st_next.r[`RTCAC_A_C2][`RTCAC_C2_A2F] = 1'b1;
            end
        end
        // Level-mode periodic events
        if (tick) begin
            case (st_next.r[`RTCAC_A_C1][2:0])
                3'h4: begin
                    st_next.r[`RTCAC_A_C2][`RTCAC_C2_PERIODIC_STATE_FLAG] = 1'b1;
                end
                3'h5: begin
                    st_next.r[`RTCAC_A_C2][`RTCAC_C2_PERIODIC_STATE_FLAG] |= (st_next.r[0] == 8'h00);
                end
                3'h6: begin
                    st_next.r[`RTCAC_A_C2][`RTCAC_C2_PERIODIC_STATE_FLAG] |=
                        (st_next.r[1:0] == 16'h0000);
                end
                3'h7: begin
                    st_next.r[`RTCAC_A_C2][`RTCAC_C2_PERIODIC_STATE_FLAG] |=
                        (st_next.r[2:0] == 24'h000000) && (st_next.r[4] == 8'h01);
                end
                default: begin
                    st_next.r[`RTCAC_A_C2][`RTCAC_C2_PERIODIC_STATE_FLAG] = 1'b0;
                end
            endcase
        end
        if (!st_next.r[`RTCAC_A_C1][2]) begin
            st_next.r[`RTCAC_A_C2][`RTCAC_C2_PERIODIC_STATE_FLAG] = 1'b0;
        end
        // Disabled alarms hold no flag
        if (!st_next.r[`RTCAC_A_C1][`RTCAC_C1_A1E]) begin
            st_next.r[`RTCAC_A_C2][`RTCAC_C2_A1F] = 1'b0;
        end
        if (!st_next.r[`RTCAC_A_C1][`RTCAC_C1_A2E]) begin
            st_next.r[`RTCAC_A_C2][`RTCAC_C2_A2F] = 1'b0;
        end
        // Halt latch, then forced control bits
        if (dead) begin
            st_next.r[`RTCAC_A_C2][`RTCAC_C2_OSC_HALT_STATUS] = 1'b1;
        end
        if (st_next.r[`RTCAC_A_C2][`RTCAC_C2_OSC_HALT_STATUS]) begin
            st_next.r[`RTCAC_A_TRIM] = 8'h00;
            st_next.r[`RTCAC_A_C1] = 8'h00;
            st_next.r[`RTCAC_A_C2][`RTCAC_C2_CLOCK_OUT_CONTROL] = 1'b0;
        end
        // Pin routing by the two select bits
        st_next.irq1 = a1_act
            | (a2_act & ~st_reg.r[`RTCAC_A_C1][`RTCAC_C1_SLL])
            | (per_act & ~st_reg.r[`RTCAC_A_C1][`RTCAC_C1_SLH]);
        st_next.irq2 = (a2_act & st_reg.r[`RTCAC_A_C1][`RTCAC_C1_SLL])
            | (per_act & st_reg.r[`RTCAC_A_C1][`RTCAC_C1_SLH]);
    end

    // System-domain register; halt is set from power-up
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_reg                    <= '0;
            st_reg.r[`RTCAC_A_DATE]   <= `RTCAC_RST_DATE;
            st_reg.r[`RTCAC_A_MON]    <= `RTCAC_RST_MON;
            st_reg.r[`RTCAC_A_C2]     <= `RTCAC_RST_C2;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule : rtcac_core
`default_nettype wire

// ### tb/rtcac_host.sv
`timescale 1ns/1ns
`default_nettype none
`include "rtcac_defs.svh"
// ==========
// Host model
module rtcac_host (
    input  wire logic sys_clk,
    input  wire logic sda_line,
    output logic      scl_line,
    output logic      sda_low
);
    logic all_ack = 1'b1;
    // Bus idle: both lines released
    initial begin
        scl_line = 1'b1;
        sda_low  = 1'b0;
    end
    // Slow half bit so the sync pipe never misses an edge
    task automatic hp;
        repeat (10) @(negedge sys_clk);
    endtask : hp
    // One bit out, line level in at the high phase
    task automatic bit_io(input logic b, output logic s);
        sda_low = !b;
        hp();
        scl_line = 1'b1;
        hp();
        s = sda_line;
        scl_line = 1'b0;
    endtask : bit_io
    // Start or repeated start
    task automatic start;
        sda_low = 1'b0;
        hp();
        scl_line = 1'b1;
        hp();
        sda_low = 1'b1;
        hp();
        scl_line = 1'b0;
    endtask : start
    task automatic stop;
        sda_low = 1'b1;
        hp();
        scl_line = 1'b1;
        hp();
        sda_low = 1'b0;
        hp();
    endtask : stop
    // Eight bits MSB first, ninth bit released
    task automatic xfer(input logic [7:0] b, output logic [7:0] r, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
        bit_io(1'b1, s);
        ack = !s;
    endtask : xfer
    task automatic wr(input logic [3:0] p, input logic [7:0] d [16], input int n);
        logic [7:0] r;
        logic       a;
        start();
        xfer({`RTCAC_DEV_ADDR, 1'b0}, r, a);
        all_ack &= a;
        xfer({4'h0, p}, r, a);
        all_ack &= a;
        for (int i = 0; i < n; i++) begin
            xfer(d[i], r, a);
            all_ack &= a;
        end
        stop();
    endtask : wr
    // Pointer write, repeated start, one byte read, host NACK
    task automatic rd(input logic [3:0] p, output logic [7:0] r);
        logic a;
        start();
        xfer({`RTCAC_DEV_ADDR, 1'b0}, r, a);
        xfer({4'h0, p}, r, a);
        start();
        xfer({`RTCAC_DEV_ADDR, 1'b1}, r, a);
        all_ack &= a;
        xfer(8'hFF, r, a);
        stop();
    endtask : rd
endmodule : rtcac_host
`default_nettype wire

// ### tb/rtcac_core_sva.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// Port checker
module rtcac_core_sva (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic osc_clk,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic irq_pin_one_out,
    input wire logic irq_pin_one_oe,
    input wire logic irq_pin_two_out,
    input wire logic crystal_clock_out_pin
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    chk_sda_open_drain: assert property (!sda_out)
        else $error("data pin driven high");
    chk_pin_one_drain: assert property (!irq_pin_one_out)
        else $error("pin one driven high");
    chk_pin_two_drain: assert property (!irq_pin_two_out)
        else $error("pin two driven high");
    chk_clock_out_gate: assert property (crystal_clock_out_pin |-> osc_clk)
        else $error("clock out high while crystal low");
    chk_idle_after_reset: assert property ($fell(rst) |-> !sda_oe && !irq_pin_one_oe)
        else $error("pins not released after reset");
    chk_ack_holds: assert property ($rose(sda_oe) |-> sda_oe [*8])
        else $error("data pull too short");
    chk_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in, 2))
        else $error("data changed near clock high");
    chk_pin_one_hold: assert property ($rose(irq_pin_one_oe) |-> irq_pin_one_oe [*8])
        else $error("pin one event too short");
    // Main scenarios
    cov_ack: cover property ($rose(sda_oe));
    cov_pin_one: cover property ($rose(irq_pin_one_oe));
    cov_clock_out: cover property ($rose(crystal_clock_out_pin));
endmodule : rtcac_core_sva
bind rtcac_core rtcac_core_sva u_rtcac_core_sva (.sys_clk, .rst, .osc_clk, .scl_in, .sda_out,
    .sda_oe, .irq_pin_one_out, .irq_pin_one_oe, .irq_pin_two_out, .crystal_clock_out_pin);
`default_nettype wire

// ### tb/tb_rtcac_core.sv
`timescale 1ns/1ns
`default_nettype none
`include "rtcac_defs.svh"
module tb_rtcac_core;
    localparam int DIV = 4096;
    logic sys_clk = 1'b0;
    logic osc_clk = 1'b0;
    logic rst     = 1'b1;
    logic scl_line, sda_low, sda_oe, p1_oe, p2_oe, ck_out;
    wire logic sda_line = !(sda_low || sda_oe); // Pull-up on the data wire
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    // ==========
    // Clocks, phases unrelated
    always #20 sys_clk = !sys_clk;
    initial begin
        #7;
        forever #16 osc_clk = !osc_clk;
    end
    rtcac_host u_rtcac_host (.sys_clk(sys_clk), .sda_line(sda_line), .scl_line(scl_line),
        .sda_low(sda_low));
    rtcac_core #(.DIV_FAST(DIV), .DIV_SLOW(4000), .TRIM_SECS(20), .HALT_CYC(2000)) u_rtcac_core (
        .sys_clk(sys_clk), .rst(rst), .osc_clk(osc_clk), .scl_in(scl_line), .sda_in(sda_line),
        .sda_out(), .sda_oe(sda_oe), .irq_pin_one_out(), .irq_pin_one_oe(p1_oe),
        .irq_pin_two_out(), .irq_pin_two_oe(p2_oe), .crystal_clock_out_pin(ck_out));
    task automatic report_and_stop;
        if (n_fail == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] v;
        u_rtcac_host.rd(a, v);
        chk($sformatf("reg %h", a), e, v);
    endtask : rchk
    // Hang guard, well above the expected run
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 98000) begin
            n_fail++;
            report_and_stop();
        end
    end
    // ==========
    // Main sequence
    initial begin
        logic [7:0] d [16];
        logic [7:0] v;
        logic       a;
        int         hc;
        int         h2;
        repeat (16) @(negedge sys_clk);
        rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        rchk(`RTCAC_A_C2, 8'h10);
        rchk(`RTCAC_A_DATE, 8'h01);
        d[0] = 8'hFF;
        u_rtcac_host.wr(`RTCAC_A_C1, d, 1);
        rchk(`RTCAC_A_C1, 8'h00);
        d[0] = 8'h10;
        u_rtcac_host.wr(`RTCAC_A_C2, d, 1);
        rchk(`RTCAC_A_C2, 8'h00);
        u_rtcac_host.start();
        u_rtcac_host.xfer(8'h20, v, a);
        u_rtcac_host.stop();
        chk("foreign address ack", 8'h00, {7'h0, a});
        for (int i = 0; i < 4; i++) begin
            d[0] = 8'hFF;
            u_rtcac_host.wr(16'h359A >> (12 - 4 * i), d, 1);
            rchk(16'h359A >> (12 - 4 * i), 32'h071F3F7F >> (24 - 8 * i));
        end
        // Clock out on, then off
        for (int k = 0; k < 2; k++) begin
            hc = 0;
            h2 = 0;
            repeat (40) @(negedge sys_clk) begin
                hc += ck_out;
                h2 += p2_oe;
            end
            chk("clock out toggles", {7'h0, k == 0}, {7'h0, hc > 5});
            chk("pin two clock", {7'h0, k == 0}, {7'h0, h2 > 5});
            d[0] = 8'h08;
            u_rtcac_host.wr(`RTCAC_A_C2, d, 1);
        end
        d[0] = 8'h80;
        u_rtcac_host.wr(`RTCAC_A_C1, d, 1);
        // Feb 28 rollover, leap and plain year
        for (int i = 0; i < 2; i++) begin
            d = '{8'h56, 8'h59, 8'h23, 8'h06, 8'h28, 8'h02, 8'h24, 8'h00,
                  8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
            d[6] = 8'h24 - 8'(i);
            d[10] = i ? 8'h7E : 8'h01;
            u_rtcac_host.wr(4'h0, d, 11);
            repeat (5 * DIV) @(posedge osc_clk);
            @(negedge sys_clk);
            chk("pin one alarm", {7'h0, i == 0}, {7'h0, p1_oe});
            rchk(`RTCAC_A_DATE, i ? 8'h01 : 8'h29);
            rchk(`RTCAC_A_MON, i ? 8'h03 : 8'h02);
            rchk(`RTCAC_A_WDAY, 8'h00);
            rchk(`RTCAC_A_YEAR, 8'h24 - 8'(i));
            rchk(`RTCAC_A_C2, i ? 8'h00 : 8'h0A);
            d[0] = 8'h00;
            u_rtcac_host.wr(`RTCAC_A_C2, d, 1);
        end
        // Periodic off, held low on pin one, routed to pin two
        for (int i = 0; i < 3; i++) begin
            d[0] = 24'h000121 >> (16 - 8 * i);
            u_rtcac_host.wr(`RTCAC_A_C1, d, 1);
            rchk(`RTCAC_A_C1, d[0]);
            chk("pin one periodic", {7'h0, i == 1}, {7'h0, p1_oe});
            rchk(`RTCAC_A_C2, i ? 8'h04 : 8'h00);
        end
        chk("all acks", 8'h01, {7'h0, u_rtcac_host.all_ack});
        report_and_stop();
    end
endmodule : tb_rtcac_core
`default_nettype wire
